// ### rtl/srb_regs.svh
`ifndef SRB_REGS_SVH
`define SRB_REGS_SVH

// ----------------------------------------------------------------
// opcodes handled by this execution group
// ----------------------------------------------------------------
`define OP_POP_DIR         8'hD0
`define OP_PUSH_DIR        8'hC0
`define OP_SUB_RETURN      8'h22
`define OP_IRQ_RETURN      8'h32
`define OP_ROT_LEFT        8'h23
`define OP_ROT_LEFT_CY     8'h33
`define OP_ROT_RIGHT       8'h03
`define OP_ROT_RIGHT_CY    8'h13
`define OP_SET_CARRY       8'hD3
`define OP_SET_BIT         8'hD2
`define OP_SHORT_JUMP      8'h80

// ----------------------------------------------------------------
// address map and reset values
// ----------------------------------------------------------------
`define SFR_SPACE_BIT      7
`define STACK_PTR_SFR      8'h81
`define STACK_PTR_RESET    8'h07
`define BIT_AREA_BASE      8'h20
`define PC_STEP_ONE        16'h0001
`define PC_STEP_TWO        16'h0002

`endif

// ### rtl/srb_pkg.sv
package srb_pkg;

   // execution sequence states
   typedef enum logic [3:0] {
      S_IDLE,
      S_POP_RD,
      S_POP_WR,
      S_PUSH_SRC,
      S_PUSH_WR,
      S_RET_HI,
      S_RET_LO,
      S_RET_PC,
      S_SETB_RD,
      S_SETB_WR,
      S_FINISH
   } exec_state_t;

   // decoded instruction kinds
   typedef enum logic [3:0] {
      K_NONE,
      K_POP,
      K_PUSH,
      K_RET,
      K_RETI,
      K_ROT_LEFT,
      K_ROT_LEFT_CY,
      K_ROT_RIGHT,
      K_ROT_RIGHT_CY,
      K_SETB_C,
      K_SETB_BIT,
      K_SJMP
   } instr_kind_t;

endpackage

// ### rtl/srb_iram.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// internal data ram, one port, registered read data
// ----------------------------------------------------------------
module srb_iram #(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 8
) (
   input  wire logic              clk,    // core clock
   input  wire logic              nrst,   // async reset, low
   input  wire logic [ADDR_W-1:0] addr,   // byte address
   input  wire logic              we,     // write strobe
   input  wire logic [DATA_W-1:0] wdata,  // write data
   output logic      [DATA_W-1:0] rdata   // data of addr, one cycle later
);

   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   // storage has no reset; contents are left to software
   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[addr] <= wdata;
      end
   end

   // read data register; a write reads back old contents
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rdata <= '0;
      end
      else
      begin
         rdata <= mem[addr];
      end
   end

endmodule

// ### rtl/stack_rotate_branch_exec.sv
// Overview of operation
// - pop reads ram at pointer, decrements pointer, writes byte to direct target
// - pop into the stack pointer leaves the popped value as pointer
// - push increments pointer, then stores direct byte at new pointer
// - return loads pc high then low from stack, pointer minus two
// - interrupt return restores pc likewise and releases the serviced priority level
// - interrupt return alters only pc and stack pointer, status word untouched
// - after interrupt return one more instruction completes before pending vectoring
// - rotate left moves bit 7 into bit 0, carry unchanged
// - rotate left through carry: bit 7 to carry, carry to bit 0
// - rotate right moves bit 0 into bit 7, carry unchanged
// - rotate right through carry: bit 0 to carry, carry to bit 7
// - set bit forces carry or an addressable bit to one only
// - short jump target is pc plus two plus signed displacement
`timescale 1ns/1ps
`include "srb_regs.svh"

module stack_rotate_branch_exec (
   input  wire logic                CORE_CLK,          // core clock, 200 MHz
   input  wire logic                NRST,              // async reset, low
   input  wire logic                INSTR_START,       // pulse: opcode presented
   input  wire logic [7:0]          OPCODE,            // first instruction byte
   input  wire logic [7:0]          OPERAND,           // second instruction byte
   input  wire logic [15:0]         PC_IN,             // address of the instruction
   input  wire logic [7:0]          ACC_IN,            // current accumulator
   input  wire logic                CY_IN,             // current carry flag
   input  wire logic [7:0]          SFR_RD_DATA,       // sfr byte, cycle after request
   input  wire logic                INSTR_RETIRE,      // pulse: other instruction done
   output logic                     BUSY,              // sequence in progress
   output logic                     DONE,              // pulse: instruction finished
   output srb_pkg::exec_state_t     EXEC_STATE,        // current sequence state
   output logic [15:0]              PC_OUT,            // next program counter
   output logic                     PC_LOAD,           // pulse: load PC_OUT
   output logic [7:0]               ACC_OUT,           // new accumulator
   output logic                     ACC_WE,            // pulse: write accumulator
   output logic                     CY_OUT,            // new carry
   output logic                     CY_WE,             // pulse: write carry
   output logic [7:0]               STACK_PTR,         // stack pointer
   output logic                     DIR_WR_EN,         // pulse: sfr byte write
   output logic [7:0]               DIR_WR_ADDR,       // sfr write address
   output logic [7:0]               DIR_WR_DATA,       // sfr write data
   output logic                     SFR_RD_REQ,        // pulse: sfr byte read
   output logic [7:0]               SFR_RD_ADDR,       // sfr read address
   output logic                     BIT_SET,           // pulse: set sfr bit
   output logic [7:0]               BIT_ADDR,          // sfr bit address
   output logic                     IRQ_LEVEL_RELEASE, // pulse: priority level free
   output logic                     IRQ_HOLD_ONE       // level: hold off vectoring
);
   import srb_pkg::*;

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------

   // opcode to kind; unknown opcodes map to K_NONE and are not taken
   function automatic instr_kind_t decode_kind(input logic [7:0] op);
      instr_kind_t k;
      k = K_NONE;
      case (op)
         `OP_POP_DIR:      k = K_POP;
         `OP_PUSH_DIR:     k = K_PUSH;
         `OP_SUB_RETURN:   k = K_RET;
         `OP_IRQ_RETURN:   k = K_RETI;
         `OP_ROT_LEFT:     k = K_ROT_LEFT;
         `OP_ROT_LEFT_CY:  k = K_ROT_LEFT_CY;
         `OP_ROT_RIGHT:    k = K_ROT_RIGHT;
         `OP_ROT_RIGHT_CY: k = K_ROT_RIGHT_CY;
         `OP_SET_CARRY:    k = K_SETB_C;
         `OP_SET_BIT:      k = K_SETB_BIT;
         `OP_SHORT_JUMP:   k = K_SJMP;
         default:          k = K_NONE;
      endcase
      return k;
   endfunction

   // {carry, accumulator} after a rotate
   function automatic logic [8:0] rotate(input instr_kind_t k, input logic [7:0] a,
                                         input logic c);
      logic [8:0] r;
      r = {c, a};
      case (k)
         K_ROT_LEFT:     r = {c, a[6:0], a[7]};
         K_ROT_LEFT_CY:  r = {a[7], a[6:0], c};
         K_ROT_RIGHT:    r = {c, a[0], a[7:1]};
         K_ROT_RIGHT_CY: r = {a[0], c, a[7:1]};
         default:        r = {c, a};
      endcase
      return r;
   endfunction

   // ram byte that holds a bit of the low bit-addressable area
   function automatic logic [7:0] bit_byte(input logic [7:0] b);
      return `BIT_AREA_BASE | {4'h0, b[6:3]};
   endfunction

   function automatic logic is_rotate(input instr_kind_t k);
      return (k == K_ROT_LEFT) || (k == K_ROT_LEFT_CY) ||
             (k == K_ROT_RIGHT) || (k == K_ROT_RIGHT_CY);
   endfunction

   // ----------------------------------------------------------------
   // internal state
   // ----------------------------------------------------------------
   exec_state_t state;
   exec_state_t next_state;
   instr_kind_t kind;
   logic [7:0]  operand_q;
   logic [15:0] pc_q;
   logic [7:0]  pc_hi_q;
   logic [7:0]  ram_addr;
   logic        ram_we;
   logic [7:0]  ram_wdata;
   logic [7:0]  ram_rdata;

   // ----------------------------------------------------------------
   // start decode
   // ----------------------------------------------------------------

   // requests while busy or with a foreign opcode are ignored
   wire instr_kind_t kind_in   = decode_kind(OPCODE);
   wire logic        go        = INSTR_START && (state == S_IDLE) && (kind_in != K_NONE);
   wire logic        two_byte  = (kind_in == K_POP) || (kind_in == K_PUSH) ||
                                 (kind_in == K_SETB_BIT) || (kind_in == K_SJMP);
   wire logic [15:0] pc_seq    = PC_IN + (two_byte ? `PC_STEP_TWO : `PC_STEP_ONE);
   wire logic [15:0] pc_jump   = pc_seq + {{8{OPERAND[7]}}, OPERAND};
   wire logic [15:0] pc_start  = (kind_in == K_SJMP) ? pc_jump : pc_seq;
   wire logic [8:0]  rot       = rotate(kind_in, ACC_IN, CY_IN);
   wire logic        sfr_bit   = OPERAND[`SFR_SPACE_BIT];
   wire logic        op_is_sfr = operand_q[`SFR_SPACE_BIT];
   wire logic        op_is_sp  = (operand_q == `STACK_PTR_SFR);

   // ----------------------------------------------------------------
   // sequence control
   // ----------------------------------------------------------------

   // every sequence ends in S_FINISH so all result strobes share the DONE cycle
   always_comb
   begin
      next_state = state;
      case (state)
         S_IDLE:
         begin
            if (go)
            begin
               case (kind_in)
                  K_POP:          next_state = S_POP_RD;
                  K_PUSH:         next_state = S_PUSH_SRC;
                  K_RET, K_RETI:  next_state = S_RET_HI;
                  K_SETB_BIT:     next_state = sfr_bit ? S_FINISH : S_SETB_RD;
                  default:        next_state = S_FINISH;
               endcase
            end
         end
         S_POP_RD:   next_state = S_POP_WR;
         S_POP_WR:   next_state = S_FINISH;
         S_PUSH_SRC: next_state = S_PUSH_WR;
         S_PUSH_WR:  next_state = S_FINISH;
         S_RET_HI:   next_state = S_RET_LO;
         S_RET_LO:   next_state = S_RET_PC;
         S_RET_PC:   next_state = S_FINISH;
         S_SETB_RD:  next_state = S_SETB_WR;
         S_SETB_WR:  next_state = S_FINISH;
         S_FINISH:   next_state = S_IDLE;
         default:    next_state = S_IDLE;
      endcase
   end

   wire logic enter_fin = (next_state == S_FINISH);

   // ----------------------------------------------------------------
   // stack pointer and ram port
   // ----------------------------------------------------------------

   // pointer arithmetic stays eight bits, so it wraps
   wire logic [7:0] sp_down = STACK_PTR - 8'h01;
   wire logic [7:0] sp_up   = STACK_PTR + 8'h01;

   // pop into the pointer: the decrement is overwritten by the byte read
   wire logic [7:0] next_sp =
      (state == S_POP_WR)   ? (op_is_sp ? ram_rdata : sp_down) :
      (state == S_PUSH_SRC) ? sp_up :
      ((state == S_RET_HI) || (state == S_RET_LO)) ? sp_down :
      STACK_PTR;

   // push source: pointer already incremented, low ram, or sfr return data
   wire logic [7:0] push_data = op_is_sp  ? STACK_PTR :
                                op_is_sfr ? SFR_RD_DATA : ram_rdata;

   // stack traffic only ever reaches the internal ram
   assign ram_addr  = ((state == S_POP_RD) || (state == S_RET_HI) ||
                       (state == S_RET_LO) || (state == S_PUSH_WR)) ? STACK_PTR :
                      ((state == S_SETB_RD) || (state == S_SETB_WR)) ? bit_byte(operand_q) :
                      operand_q;
   assign ram_we    = ((state == S_POP_WR) && !op_is_sfr) ||
                      (state == S_PUSH_WR) ||
                      (state == S_SETB_WR);
   assign ram_wdata = (state == S_PUSH_WR) ? push_data :
                      (state == S_SETB_WR) ? (ram_rdata | (8'h01 << operand_q[2:0])) :
                      ram_rdata;

   srb_iram #(
      .ADDR_W (8),
      .DATA_W (8)
   ) u_iram (
      .clk   (CORE_CLK),
      .nrst  (NRST),
      .addr  (ram_addr),
      .we    (ram_we),
      .wdata (ram_wdata),
      .rdata (ram_rdata)
   );

   // ----------------------------------------------------------------
   // result outputs
   // ----------------------------------------------------------------

   // stack instructions and returns never touch accumulator or flags
   wire logic        next_acc_we  = go && is_rotate(kind_in);
   wire logic [7:0]  next_acc_out = go ? rot[7:0] : ACC_OUT;
   wire logic        next_cy_we   = go && ((kind_in == K_ROT_LEFT_CY) ||
                                           (kind_in == K_ROT_RIGHT_CY) ||
                                           (kind_in == K_SETB_C));
   wire logic        next_cy_out  = !go ? CY_OUT :
                                    (kind_in == K_SETB_C) ? 1'b1 : rot[8];
   wire logic        next_bit_set = go && (kind_in == K_SETB_BIT) && sfr_bit;
   wire logic [7:0]  next_bit_adr = go ? OPERAND : BIT_ADDR;

   // return address comes from the two stack bytes, high byte first
   wire logic [15:0] next_pc_out  = !enter_fin ? PC_OUT :
                                    (state == S_RET_PC) ? {pc_hi_q, ram_rdata} :
                                    (state == S_IDLE) ? pc_start : pc_q;

   // a pop into the pointer is handled here, not written out to the sfr bus
   wire logic        next_dir_we  = (state == S_POP_WR) && op_is_sfr && !op_is_sp;
   wire logic        next_sfr_req = go && (kind_in == K_PUSH) && sfr_bit &&
                                    (OPERAND != `STACK_PTR_SFR);

   // interrupt return frees its level in the DONE cycle
   wire logic        next_release = enter_fin && (kind == K_RETI) &&
                                    (state == S_RET_PC);

   // hold off vectoring until one more instruction retires; a new set wins
   wire logic        hold_clear   = IRQ_HOLD_ONE && (INSTR_RETIRE ||
                                                     (DONE && !IRQ_LEVEL_RELEASE));
   wire logic        next_hold    = next_release ? 1'b1 :
                                    hold_clear ? 1'b0 : IRQ_HOLD_ONE;

   // ----------------------------------------------------------------
   // sequencing registers
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         state     <= S_IDLE;
         kind      <= K_NONE;
         operand_q <= 8'h00;
         pc_q      <= 16'h0000;
         pc_hi_q   <= 8'h00;
         STACK_PTR <= `STACK_PTR_RESET;
      end
      else
      begin
         state     <= next_state;
         kind      <= go ? kind_in : kind;
         operand_q <= go ? OPERAND : operand_q;
         pc_q      <= go ? pc_start : pc_q;
         pc_hi_q   <= (state == S_RET_LO) ? ram_rdata : pc_hi_q;
         STACK_PTR <= next_sp;
      end
   end

   // ----------------------------------------------------------------
   // output registers
   // ----------------------------------------------------------------

   // result strobes are aligned with DONE so the core commits them together
   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         BUSY              <= 1'b0;
         DONE              <= 1'b0;
         EXEC_STATE        <= S_IDLE;
         PC_OUT            <= 16'h0000;
         PC_LOAD           <= 1'b0;
         ACC_OUT           <= 8'h00;
         ACC_WE            <= 1'b0;
         CY_OUT            <= 1'b0;
         CY_WE             <= 1'b0;
         DIR_WR_EN         <= 1'b0;
         DIR_WR_ADDR       <= 8'h00;
         DIR_WR_DATA       <= 8'h00;
         SFR_RD_REQ        <= 1'b0;
         SFR_RD_ADDR       <= 8'h00;
         BIT_SET           <= 1'b0;
         BIT_ADDR          <= 8'h00;
         IRQ_LEVEL_RELEASE <= 1'b0;
         IRQ_HOLD_ONE      <= 1'b0;
      end
      else
      begin
         BUSY              <= (next_state != S_IDLE);
         DONE              <= enter_fin;
         EXEC_STATE        <= next_state;
         PC_OUT            <= next_pc_out;
         PC_LOAD           <= enter_fin;
         ACC_OUT           <= next_acc_out;
         ACC_WE            <= next_acc_we;
         CY_OUT            <= next_cy_out;
         CY_WE             <= next_cy_we;
         DIR_WR_EN         <= next_dir_we;
         DIR_WR_ADDR       <= next_dir_we ? operand_q : DIR_WR_ADDR;
         DIR_WR_DATA       <= next_dir_we ? ram_rdata : DIR_WR_DATA;
         SFR_RD_REQ        <= next_sfr_req;
         SFR_RD_ADDR       <= next_sfr_req ? OPERAND : SFR_RD_ADDR;
         BIT_SET           <= next_bit_set;
         BIT_ADDR          <= next_bit_adr;
         IRQ_LEVEL_RELEASE <= next_release;
         IRQ_HOLD_ONE      <= next_hold;
      end
   end

endmodule

// ### test/srb_exec_sva.sv
`timescale 1ns/1ps
`include "srb_regs.svh"

// ----------------------------------------------------------------
// port-level checker for the stack, rotate and branch group
// ----------------------------------------------------------------
module srb_exec_sva (
   input wire logic        CORE_CLK,          // core clock
   input wire logic        NRST,              // async reset, low
   input wire logic        INSTR_START,       // start pulse
   input wire logic [7:0]  OPCODE,            // first byte
   input wire logic [7:0]  OPERAND,           // second byte
   input wire logic [15:0] PC_IN,             // instruction address
   input wire logic [7:0]  ACC_IN,            // accumulator in
   input wire logic        CY_IN,             // carry in
   input wire logic        BUSY,              // sequence running
   input wire logic        DONE,              // finish pulse
   input wire logic [15:0] PC_OUT,            // next pc
   input wire logic        PC_LOAD,           // pc load pulse
   input wire logic [7:0]  ACC_OUT,           // accumulator out
   input wire logic        ACC_WE,            // accumulator write
   input wire logic        CY_OUT,            // carry out
   input wire logic        CY_WE,             // carry write
   input wire logic [7:0]  STACK_PTR,         // stack pointer
   input wire logic        IRQ_LEVEL_RELEASE, // level freed
   input wire logic        IRQ_HOLD_ONE       // vectoring held off
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);

   // a request counts only when the sequencer is idle
   wire logic take = INSTR_START && !BUSY;
   wire logic rot  = OPCODE[1:0] == 2'b11 && OPCODE[7:6] == 2'b00 && OPCODE[3:2] == 2'b00;
   wire logic stk  = OPCODE == `OP_POP_DIR || OPCODE == `OP_PUSH_DIR
                   || OPCODE == `OP_SUB_RETURN || OPCODE == `OP_IRQ_RETURN;

   sequence s_take(logic [7:0] op);
      take && OPCODE == op;
   endsequence
   // reti ends by freeing the level, then holds off vectoring one instruction
   sequence s_reti_end;
      DONE && IRQ_LEVEL_RELEASE ##1 IRQ_HOLD_ONE;
   endsequence

   a_rot_left_val: assert property (s_take(`OP_ROT_LEFT) |=> ACC_WE && !CY_WE
      && ACC_OUT == {$past(ACC_IN[6:0]), $past(ACC_IN[7])}) else $error("rotate left");
   a_rlc_val: assert property (s_take(`OP_ROT_LEFT_CY) |=> CY_WE && ACC_WE
      && CY_OUT == $past(ACC_IN[7]) && ACC_OUT == {$past(ACC_IN[6:0]), $past(CY_IN)})
      else $error("rotate left carry");
   a_rr_val: assert property (s_take(`OP_ROT_RIGHT) |=> ACC_WE && !CY_WE
      && ACC_OUT == (($past(ACC_IN) >> 1) | ($past(ACC_IN) << 7))) else $error("rotate right");
   a_rrc_val: assert property (s_take(`OP_ROT_RIGHT_CY) |=> CY_WE
      && {7'h00, CY_OUT} == ($past(ACC_IN) & 8'h01)
      && ACC_OUT == (($past(ACC_IN) >> 1) | {$past(CY_IN), 7'h00})) else $error("rotate right carry");
   a_rot_pc_step: assert property (take && rot |=> PC_LOAD && PC_OUT == $past(PC_IN) + 16'h0001)
      else $error("one-byte pc step");
   a_sjmp_target: assert property (s_take(`OP_SHORT_JUMP) |=> PC_LOAD
      && PC_OUT == $past(PC_IN) + 16'h0002 + 16'($signed($past(OPERAND)))) else $error("jump target");
   a_push_sp_up: assert property (s_take(`OP_PUSH_DIR) |-> ##3 DONE
      && STACK_PTR == $past(STACK_PTR, 3) + 8'h01) else $error("push pointer");
   a_pop_sp_down: assert property (s_take(`OP_POP_DIR) && OPERAND != `STACK_PTR_SFR |-> ##3 DONE
      && STACK_PTR == $past(STACK_PTR, 3) - 8'h01) else $error("pop pointer");
   a_ret_sp_two: assert property (take && (OPCODE == `OP_SUB_RETURN || OPCODE == `OP_IRQ_RETURN)
      |-> ##4 DONE && PC_LOAD && STACK_PTR == $past(STACK_PTR, 4) - 8'h02) else $error("return");
   a_reti_release: assert property (s_take(`OP_IRQ_RETURN) |-> ##4 s_reti_end)
      else $error("level release");
   a_stack_no_flags: assert property (take && stk |=> (!ACC_WE && !CY_WE)[*4])
      else $error("stack op wrote flags");
   a_setb_carry: assert property (s_take(`OP_SET_CARRY) |=> CY_WE && CY_OUT && !ACC_WE)
      else $error("set carry");
endmodule

bind stack_rotate_branch_exec srb_exec_sva i_sva (.*);

// ### test/testbench.sv
`timescale 1ns/1ps
`include "srb_regs.svh"

module testbench;
   import srb_pkg::*;
   // ----------------------------------------------------------------
   // design ports and bench state
   // ----------------------------------------------------------------
   logic        CORE_CLK = 1'b0, NRST = 1'b0, INSTR_START = 1'b0, INSTR_RETIRE = 1'b0;
   logic        CY_IN = 1'b0;
   logic [7:0]  OPCODE = 8'h00, OPERAND = 8'h00, ACC_IN = 8'h00, SFR_RD_DATA = 8'h00;
   logic [15:0] PC_IN = 16'h0000;
   logic        BUSY, DONE, PC_LOAD, ACC_WE, CY_OUT, CY_WE, DIR_WR_EN, SFR_RD_REQ, BIT_SET;
   logic        IRQ_LEVEL_RELEASE, IRQ_HOLD_ONE;
   logic [7:0]  ACC_OUT, STACK_PTR, DIR_WR_ADDR, DIR_WR_DATA, SFR_RD_ADDR, BIT_ADDR;
   logic [15:0] PC_OUT;
   exec_state_t EXEC_STATE;
   int          err_count = 0, checked = 0, cycles = 0, lat;
   logic [7:0]  rd_addr;

   // clock: 5 ns period
   always #2.5 CORE_CLK = ~CORE_CLK;

   stack_rotate_branch_exec i_dut (.*);

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one instruction; returns in the DONE cycle, or eight cycles after start if DONE never comes
   task automatic run(input logic [7:0] op, opr, input logic [15:0] pc,
                      input logic [7:0] acc, input logic cy, input logic [7:0] sd);
      @(negedge CORE_CLK);
      OPCODE = op; OPERAND = opr; PC_IN = pc; ACC_IN = acc; CY_IN = cy;
      SFR_RD_DATA = sd;
      INSTR_START = 1'b1;
      rd_addr = 8'h00;
      @(negedge CORE_CLK);
      INSTR_START = 1'b0;
      for (lat = 1; lat < 8; lat++)
      begin
         if (SFR_RD_REQ === 1'b1) rd_addr = SFR_RD_ADDR;
         if (DONE === 1'b1) break;
         @(negedge CORE_CLK);
      end
   endtask

   // push from sfr 90h, pop to sfr a0h
   task automatic push_sfr(input logic [7:0] v);
      run(`OP_PUSH_DIR, 8'h90, 16'h0000, 8'h00, 1'b0, v);
   endtask
   task automatic pop_sfr;
      run(`OP_POP_DIR, 8'hA0, 16'h0000, 8'h00, 1'b0, 8'h00);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_push_pop;
      run(`OP_PUSH_DIR, 8'h90, 16'h0200, 8'h00, 1'b0, 8'h5A);
      chk("push cycles", 16'd3, 16'(lat));
      chk("push src addr", 16'h0090, 16'(rd_addr));
      chk("push sp", 16'h0008, 16'(STACK_PTR));
      chk("push pc", 16'h0202, PC_OUT);
      run(`OP_POP_DIR, 8'hA0, 16'h0202, 8'h00, 1'b0, 8'h00);
      chk("pop wr", 16'h01A0, {7'h00, DIR_WR_EN, DIR_WR_ADDR});
      chk("pop data", 16'h005A, 16'(DIR_WR_DATA));
      chk("pop sp", 16'h0007, 16'(STACK_PTR));
      chk("pop flags", 16'h0000, {14'h0, ACC_WE, CY_WE});
      $display("push and pop done");
   endtask

   task automatic t_returns;
      for (int i = 0; i < 2; i++)
      begin
         push_sfr(8'h23);
         push_sfr(8'h01);
         run(i ? `OP_IRQ_RETURN : `OP_SUB_RETURN, 8'h00, 16'h0300, 8'h00, 1'b0, 8'h00);
         chk("ret cycles", 16'd4, 16'(lat));
         chk("ret pc", 16'h0123, PC_OUT);
         chk("ret sp", 16'h0007, 16'(STACK_PTR));
         chk("ret regs", 16'h0000, {14'h0, ACC_WE, CY_WE});
         chk("ret release", 16'(i), 16'(IRQ_LEVEL_RELEASE));
      end
      @(negedge CORE_CLK);
      chk("hold one", 16'h0001, 16'(IRQ_HOLD_ONE));
      INSTR_RETIRE = 1'b1;
      @(negedge CORE_CLK);
      INSTR_RETIRE = 1'b0;
      chk("hold cleared", 16'h0000, 16'(IRQ_HOLD_ONE));
      $display("returns done");
   endtask

   task automatic t_pointer;
      push_sfr(8'hFF);
      run(`OP_POP_DIR, `STACK_PTR_SFR, 16'h0000, 8'h00, 1'b0, 8'h00);
      chk("pop into sp", 16'h00FF, 16'(STACK_PTR));
      push_sfr(8'h44);
      chk("sp wrap up", 16'h0000, 16'(STACK_PTR));
      pop_sfr();
      chk("wrap data", 16'h0044, 16'(DIR_WR_DATA));
      chk("sp wrap down", 16'h00FF, 16'(STACK_PTR));
      push_sfr(8'h07);
      run(`OP_POP_DIR, `STACK_PTR_SFR, 16'h0000, 8'h00, 1'b0, 8'h00);
      chk("sp restored", 16'h0007, 16'(STACK_PTR));
      $display("pointer done");
   endtask

   task automatic t_rotates;
      logic [7:0] ops [4] = '{`OP_ROT_LEFT, `OP_ROT_LEFT_CY, `OP_ROT_RIGHT, `OP_ROT_RIGHT_CY};
      logic [7:0] a, e;
      logic       c, ec;
      for (int i = 0; i < 8; i++)
      begin
         a = (i < 4) ? 8'hC5 : 8'h3A;
         c = (i >= 4);
         e = (i % 4 == 0) ? {a[6:0], a[7]} : (i % 4 == 1) ? {a[6:0], c}
           : (i % 4 == 2) ? {a[0], a[7:1]} : {c, a[7:1]};
         ec = (i % 4 == 1) ? a[7] : a[0];
         run(ops[i % 4], 8'h00, 16'h0400, a, c, 8'h00);
         chk("rot cycles", 16'd1, 16'(lat));
         chk("rot acc", {7'h00, 1'b1, e}, {7'h00, ACC_WE, ACC_OUT});
         chk("rot carry we", 16'(i % 2), 16'(CY_WE));
         if (i % 2) chk("rot carry", 16'(ec), 16'(CY_OUT));
         chk("rot pc", 16'h0401, PC_OUT);
      end
      $display("rotates done");
   endtask

   task automatic t_set_bits;
      run(`OP_SET_CARRY, 8'h00, 16'h0500, 8'h00, 1'b0, 8'h00);
      chk("setb c", 16'h0006, {13'h0, CY_WE, CY_OUT, ACC_WE});
      chk("setb c pc", 16'h0501, PC_OUT);
      run(`OP_SET_BIT, 8'h90, 16'h0500, 8'h00, 1'b0, 8'h00);
      chk("setb sfr", 16'h0190, {7'h00, BIT_SET, BIT_ADDR});
      chk("setb sfr pc", 16'h0502, PC_OUT);
      push_sfr(8'h00);
      run(`OP_POP_DIR, `BIT_AREA_BASE, 16'h0000, 8'h00, 1'b0, 8'h00);
      run(`OP_SET_BIT, 8'h05, 16'h0500, 8'h00, 1'b0, 8'h00);
      chk("setb ram cycles", 16'd3, 16'(lat));
      chk("setb ram flags", 16'h0000, {14'h0, ACC_WE, CY_WE});
      run(`OP_PUSH_DIR, `BIT_AREA_BASE, 16'h0000, 8'h00, 1'b0, 8'h00);
      pop_sfr();
      chk("setb ram byte", 16'h0020, 16'(DIR_WR_DATA));
      $display("set bit done");
   endtask

   task automatic t_jumps;
      logic [15:0] pcs [4] = '{16'h0100, 16'h1000, 16'h1000, 16'h0100};
      logic [7:0]  ds  [4] = '{8'h21, 8'h80, 8'h7F, 8'hFE};
      logic [15:0] tg  [4] = '{16'h0123, 16'h0F82, 16'h1081, 16'h0100};
      for (int i = 0; i < 4; i++)
      begin
         run(`OP_SHORT_JUMP, ds[i], pcs[i], 8'h00, 1'b0, 8'h00);
         chk("jump target", tg[i], PC_OUT);
      end
      run(8'h00, 8'h00, 16'h0000, 8'h00, 1'b0, 8'h00);
      chk("unknown op", 16'h0000, {10'h0, EXEC_STATE, DONE, BUSY});
      $display("jumps done");
   endtask

   // ----------------------------------------------------------------
   // main sequence and hang guard
   // ----------------------------------------------------------------
   always @(posedge CORE_CLK)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         err_count++;
         report_and_stop();
      end
   end

   initial
   begin
      repeat (3) @(negedge CORE_CLK);
      chk("reset sp", 16'h0007, 16'(STACK_PTR));
      NRST = 1'b1;
      t_push_pop();
      t_returns();
      t_pointer();
      t_rotates();
      t_set_bits();
      t_jumps();
      report_and_stop();
   end
endmodule
